// ---- core/tws_slave.sv ----
// Two-wire slave port: framing, control byte match, shifting, acknowledge.
// Assumes raw SCL/SDA pin levels and an external open-drain pad driver.
`timescale 1ns/1ps
module tws_slave (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Two-wire bus pins
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Straps and write protect
  input wire logic select_strap_bit0,
  input wire logic select_strap_bit1,
  input wire logic select_strap_bit2,
  input wire logic write_protect,
  // Received bytes
  output tws_pkg::tws_byte_t rx_data,
  output logic rx_valid,
  output logic rx_first,
  output logic wr_blocked,
  // Bytes to send
  input wire tws_pkg::tws_byte_t tx_data,
  output logic tx_take,
  // Bus status
  output logic start_seen,
  output logic stop_seen,
  output logic bus_busy,
  output logic addressed,
  output logic read_mode
);
  import tws_pkg::*;

  logic [5:0] pins;
  logic [5:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic [2:0] strap_s;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  tws_st_t r;
  tws_st_t nxt;

  // Control byte decode: type code and select bits
  function automatic logic ctrl_match(input tws_byte_t b,
                                      input logic [2:0] sel);
    logic type_ok;
    logic sel_ok;
    type_ok = b[CTRL_TYPE_MSB:CTRL_TYPE_LSB] == TWS_TYPE_CODE;
    sel_ok = b[CTRL_SEL_MSB:CTRL_SEL_LSB] == sel;
    return type_ok & sel_ok;
  endfunction

  // What the pad should do once the hold time after SCL fall expires
  function automatic logic drive_want(input tws_state_t s,
                                      input tws_byte_t sh);
    logic want;
    case (s)
      TWS_CACK: want = 1'b1;
      TWS_RACK: want = 1'b1;
      TWS_TX: want = ~sh[7];
      default: want = 1'b0;
    endcase
    return want;
  endfunction

  // Write protect resets high; after reset the synchronised pin level alone decides
  assign pins = {write_protect, select_strap_bit2, select_strap_bit1,
                 select_strap_bit0, sda_in, scl};

  tws_sync #(
    .W(6),
    .RST(SYNC_RST)
  ) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .pin(pins),
    .level(pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign strap_s = pins_s[4:2];
  assign wp_s = pins_s[5];

  // Latency from pin to event is two clocks, well inside the
  // shortest fast-mode high phase, so sampling stays in the window
  tws_cond u_cond (
    .clock(clock),
    .sys_rst(sys_rst),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start(start),
    .stop(stop)
  );

  always_comb begin
    nxt = r;
    nxt.rx_valid = 1'b0;
    nxt.blocked = 1'b0;
    nxt.tx_take = 1'b0;
    nxt.start_p = 1'b0;
    nxt.stop_p = 1'b0;

    // Drive changes wait out the hold time, then land in SCL low
    if (r.hold != 4'h0) begin
      nxt.hold = r.hold - 4'h1;
      if (r.hold == 4'h1) begin
        nxt.oe = drive_want(r.state, r.shift);
      end
    end

    if (start) begin
      // Also a repeated start: any transfer in flight is dropped
      nxt.state = TWS_CTRL;
      nxt.bitcnt = 4'h0;
      nxt.shift = 8'h00;
      nxt.first = 1'b0;
      nxt.mack = 1'b0;
      nxt.oe = 1'b0;
      nxt.hold = 4'h0;
      nxt.busy = 1'b1;
      nxt.start_p = 1'b1;
    end else if (stop) begin
      nxt.state = TWS_IDLE;
      nxt.bitcnt = 4'h0;
      nxt.oe = 1'b0;
      nxt.hold = 4'h0;
      nxt.busy = 1'b0;
      nxt.stop_p = 1'b1;
    end else if (scl_rise) begin
      case (r.state)
        TWS_CTRL: begin
          // Bits arrive most significant first
          nxt.shift = {r.shift[6:0], sda_s};
          nxt.bitcnt = r.bitcnt + 4'h1;
        end
        TWS_RX: begin
          nxt.shift = {r.shift[6:0], sda_s};
          nxt.bitcnt = r.bitcnt + 4'h1;
        end
        TWS_TX: begin
          nxt.bitcnt = r.bitcnt + 4'h1;
        end
        TWS_TACK: begin
          // Low on the ninth pulse means the master wants more
          nxt.mack = ~sda_s;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      nxt.hold = HOLD_CNT;
      case (r.state)
        TWS_CTRL: begin
          if (r.bitcnt == BYTE_BITS) begin
            if (ctrl_match(r.shift, strap_s)) begin
              nxt.state = TWS_CACK;
              nxt.dir = r.shift[CTRL_DIR_BIT];
            end else begin
              // Not ours: silent until the next start
              nxt.state = TWS_IDLE;
            end
          end
        end
        TWS_CACK: begin
          nxt.bitcnt = 4'h0;
          if (r.dir) begin
            nxt.state = TWS_TX;
            nxt.shift = tx_data;
            nxt.tx_take = 1'b1;
          end else begin
            nxt.state = TWS_RX;
            nxt.first = 1'b1;
          end
        end
        TWS_RX: begin
          if (r.bitcnt == BYTE_BITS) begin
            // Byte is acknowledged even when protection drops it
            nxt.state = TWS_RACK;
            nxt.first = 1'b0;
            if (wp_s) begin
              nxt.blocked = 1'b1;
            end else begin
              nxt.rx_valid = 1'b1;
              nxt.rx_data = r.shift;
              nxt.rx_first = r.first;
            end
          end
        end
        TWS_RACK: begin
          // No byte ceiling: the master ends with stop or start
          nxt.state = TWS_RX;
          nxt.bitcnt = 4'h0;
        end
        TWS_TX: begin
          if (r.bitcnt == BYTE_BITS) begin
            nxt.state = TWS_TACK;
            nxt.mack = 1'b0;
          end else begin
            nxt.shift = {r.shift[6:0], 1'b0};
          end
        end
        TWS_TACK: begin
          if (r.mack) begin
            nxt.state = TWS_TX;
            nxt.shift = tx_data;
            nxt.tx_take = 1'b1;
            nxt.bitcnt = 4'h0;
          end else begin
            // Line left released so the master can stop
            nxt.state = TWS_IDLE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      r <= TWS_ST_RST;
    end else begin
      r <= nxt;
    end
  end

  // Open drain: the pad only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = r.oe;
  // Protection only gates bus writes; nothing else here is held off
  assign rx_data = r.rx_data;
  assign rx_valid = r.rx_valid;
  assign rx_first = r.rx_first;
  assign wr_blocked = r.blocked;
  assign tx_take = r.tx_take;
  assign start_seen = r.start_p;
  assign stop_seen = r.stop_p;
  assign bus_busy = r.busy;
  assign addressed = (r.state != TWS_IDLE) && (r.state != TWS_CTRL);
  assign read_mode = r.dir & addressed;
endmodule

// ---- core/tws_pkg.sv ----
// Shared constants, state codes and the state record of the two-wire slave.
// Assumes a 25 MHz system clock; no other package is needed.
package tws_pkg;

  typedef logic [7:0] tws_byte_t;

  // Clock and bus rates
  localparam int CLK_PERIOD_NS = 40;
  localparam int STD_RATE_KHZ = 100;
  localparam int FAST_RATE_KHZ = 400;
  // Shortest SCL high phase at the fast rate; sampling latency must fit
  localparam int FAST_HIGH_NS = 600;
  localparam int FAST_HIGH_CYC = FAST_HIGH_NS / CLK_PERIOD_NS;
  // Shortest SCL low phase at the fast rate; drive changes land inside it
  localparam int FAST_LOW_NS = 1300;
  localparam int FAST_LOW_CYC = FAST_LOW_NS / CLK_PERIOD_NS;
  // Internal SDA hold after SCL falls, least time rounded up
  localparam int HOLD_NS = 300;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] HOLD_CNT = 4'(HOLD_CYC);

  // Control byte layout
  localparam int CTRL_TYPE_MSB = 7;
  localparam int CTRL_TYPE_LSB = 4;
  localparam int CTRL_SEL_MSB = 3;
  localparam int CTRL_SEL_LSB = 1;
  localparam int CTRL_DIR_BIT = 0;
  // Device type code; value is arbitrary
  localparam logic [3:0] TWS_TYPE_CODE = 4'h6;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Pin synchroniser reset: bus idle high, write protect asserted
  localparam logic [5:0] SYNC_RST = 6'h3f;

  typedef enum logic [6:0] {
    TWS_IDLE = 7'h01,
    TWS_CTRL = 7'h02,
    TWS_CACK = 7'h04,
    TWS_RX   = 7'h08,
    TWS_RACK = 7'h10,
    TWS_TX   = 7'h20,
    TWS_TACK = 7'h40
  } tws_state_t;

  typedef struct packed {
    tws_state_t state;
    tws_byte_t shift;
    logic [3:0] bitcnt;
    logic dir;
    logic first;
    logic mack;
    logic [3:0] hold;
    logic oe;
    logic busy;
    tws_byte_t rx_data;
    logic rx_valid;
    logic rx_first;
    logic blocked;
    logic tx_take;
    logic start_p;
    logic stop_p;
  } tws_st_t;

  localparam tws_st_t TWS_ST_RST = '{
    state: TWS_IDLE, shift: 8'h00, bitcnt: 4'h0, dir: 1'b0, first: 1'b0,
    mack: 1'b0, hold: 4'h0, oe: 1'b0, busy: 1'b0, rx_data: 8'h00,
    rx_valid: 1'b0, rx_first: 1'b0, blocked: 1'b0, tx_take: 1'b0,
    start_p: 1'b0, stop_p: 1'b0};

endpackage

// ---- core/tws_sync.sv ----
// Two-flop synchronisers for asynchronous pin levels.
// Assumes inputs from outside the clock domain; reset value per bit.
`timescale 1ns/1ps
module tws_sync #(
  parameter int W = 6,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Pins in, synchronised levels out
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        meta_r[i] <= RST[i];
        level[i] <= RST[i];
      end else begin
        meta_r[i] <= pin[i];
        level[i] <= meta_r[i];
      end
    end
  end
endmodule

// ---- core/tws_cond.sv ----
// Bus event detector: SCL edges, START and STOP from synchronised lines.
// Assumes both inputs are already in the clock domain.
`timescale 1ns/1ps
module tws_cond (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Synchronised bus levels
  input wire logic scl_s,
  input wire logic sda_s,
  // One-cycle events
  output logic scl_rise,
  output logic scl_fall,
  output logic start,
  output logic stop
);
  logic scl_q_r;
  logic sda_q_r;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q_r;
  assign scl_fall = ~scl_s & scl_q_r;
  // SDA moving while SCL stays high is a control condition
  assign start = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop = scl_s & scl_q_r & ~sda_q_r & sda_s;
endmodule

// ---- dv/tws_slave_props.sv ----
// Checker for the two-wire slave port, bound to its top module.
// Assumes the two-clock synchronised pin latency of the slave.
`timescale 1ns/1ps
module tws_slave_props (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Bus and protect
  input wire logic scl,
  input wire logic sda_oe,
  input wire logic write_protect,
  // Status
  input wire logic rx_valid,
  input wire logic wr_blocked,
  input wire logic tx_take,
  input wire logic start_seen,
  input wire logic stop_seen,
  input wire logic bus_busy,
  input wire logic addressed,
  input wire logic read_mode
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_start_opens: assert property (start_seen |=> bus_busy)
    else $error("start did not open a transfer");
  a_stop_closes: assert property (stop_seen |=> !bus_busy && !addressed)
    else $error("stop did not close the transfer");
  a_oe_low_only: assert property ($changed(sda_oe) |-> !scl || start_seen
    || stop_seen || $past(start_seen) || $past(stop_seen))
    else $error("data drive changed while clock high");
  a_ack_held: assert property ($rose(sda_oe) && !read_mode |-> sda_oe[*8])
    else $error("acknowledge not held low");
  a_ack_matched: assert property ($rose(sda_oe) |-> addressed)
    else $error("drive without a matched control byte");
  a_rx_write: assert property (rx_valid |-> addressed && !read_mode)
    else $error("byte received outside write mode");
  a_wp_blocks: assert property (rx_valid |-> !write_protect)
    else $error("byte accepted while protected");
  a_wp_allows: assert property (wr_blocked |-> write_protect)
    else $error("byte dropped while unprotected");
  a_take_read: assert property (tx_take |-> read_mode)
    else $error("byte fetched outside read mode");
  a_nack_release: assert property ($fell(read_mode) |-> !sda_oe)
    else $error("data line held after read ended");
  a_quiet_idle: assert property (!addressed && !$past(addressed) |-> !sda_oe)
    else $error("drive while not addressed");

  c_rx: cover property (rx_valid);
  c_blocked: cover property (wr_blocked);
  c_read: cover property (tx_take ##[1:400] $fell(read_mode));
endmodule

// ---- dv/tws_mst.sv ----
// Two-wire bus master model: open-drain data, clock made only here.
// Assumes a pull-up on the data wire resolved by the bench.
`timescale 1ns/1ps
module tws_mst (
  // Clock
  input wire logic clock,
  // Bus
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Idle bus first; data falls with clock high
  task automatic start();
    sda_oe <= 1'b0;
    wt(4);
    scl <= 1'b1;
    wt(8);
    sda_oe <= 1'b1;
    wt(8);
    scl <= 1'b0;
    wt(14);
  endtask

  // Data rises with clock high
  task automatic stop();
    sda_oe <= 1'b1;
    wt(2);
    scl <= 1'b1;
    wt(8);
    sda_oe <= 1'b0;
    wt(16);
  endtask

  // Long low phase: slave drive lands 11 clocks after fall
  task automatic clk_bit(input logic b, output logic s);
    sda_oe <= ~b;
    wt(2);
    scl <= 1'b1;
    wt(8);
    s = sda;
    scl <= 1'b0;
    wt(14);
  endtask

  // MSB first, then the acknowledge pulse
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask

  // Acks every byte but the last
  task automatic get(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(1'b1, d[i]);
    clk_bit(last, s);
  endtask
endmodule

// ---- dv/tws_slave_test.sv ----
// Bench for the two-wire slave: table of write cases, then a read.
// Assumes the master model and the checker files compiled before it.
`timescale 1ns/1ps
module tws_slave_test;
  import tws_pkg::*;
  typedef struct packed {
    logic [2:0] sel;
    logic bad;
    logic wp;
    logic ack;
    logic rx;
  } tws_row_t;
  localparam tws_row_t ROWS [4] = '{
    '{3'h5, 1'b0, 1'b0, 1'b1, 1'b1},
    '{3'h5, 1'b0, 1'b1, 1'b1, 1'b0},
    '{3'h4, 1'b0, 1'b0, 1'b0, 1'b0},
    '{3'h5, 1'b1, 1'b0, 1'b0, 1'b0}};
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic wp = 1'b1;
  logic [2:0] strap = 3'h5;
  tws_byte_t tx_data = 8'h3c;
  logic m_scl, m_oe, sda_oe, sda_out, sda;
  tws_byte_t rx_data;
  tws_byte_t d;
  tws_row_t r;
  logic rx_valid, rx_first, wr_blocked, tx_take, ack;
  logic fst;
  int sp_cnt = 0;
  logic start_seen, stop_seen, bus_busy, addressed, read_mode;
  int error_cnt = 0;
  int total_checks = 0;
  int rx_cnt = 0;
  int bl_cnt = 0;

  always #20 clock = ~clock;
  // Open-drain wire with pull-up
  assign sda = ~(m_oe | sda_oe);

  tws_slave dut (.clock(clock), .sys_rst(sys_rst), .scl(m_scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .select_strap_bit0(strap[0]), .select_strap_bit1(strap[1]),
    .select_strap_bit2(strap[2]), .write_protect(wp), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_first(rx_first), .wr_blocked(wr_blocked),
    .tx_data(tx_data), .tx_take(tx_take), .start_seen(start_seen),
    .stop_seen(stop_seen), .bus_busy(bus_busy), .addressed(addressed),
    .read_mode(read_mode));
  tws_mst mst (.clock(clock), .sda(sda), .scl(m_scl), .sda_oe(m_oe));

  always @(posedge clock) begin
    if (rx_valid === 1'b1)
      rx_cnt++;
    if (wr_blocked === 1'b1)
      bl_cnt++;
    if (rx_valid === 1'b1)
      fst <= rx_first;
    if (stop_seen === 1'b1)
      sp_cnt++;
    if (tx_take === 1'b1)
      tx_data <= tx_data + 8'h01;
  end

  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Whole run needs about 110 us
  initial begin
    #2000000;
    error_cnt++;
    $display("[FAIL] watchdog expected done seen hang");
    stop_test();
  end

  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk("idle oe", 8'h00, 8'(sda_oe));
    chk("idle busy", 8'h00, 8'(bus_busy));
    chk("rx_data", 8'h00, rx_data);
    $display("test reset done");
    foreach (ROWS[i]) begin
      r = ROWS[i];
      wp <= r.wp;
      mst.wt(8);
      rx_cnt = 0;
      bl_cnt = 0;
      sp_cnt = 0;
      mst.start();
      mst.put({TWS_TYPE_CODE ^ {3'h0, r.bad}, r.sel, 1'b0}, ack);
      chk("ctrl ack", 8'(r.ack), 8'(ack));
      chk("addressed", 8'(r.ack), 8'(addressed));
      if (r.ack) begin
        mst.put(8'h5a ^ 8'(i), ack);
        chk("data ack", 8'h01, 8'(ack));
      end
      mst.stop();
      chk("rx count", 8'(r.rx), 8'(rx_cnt));
      chk("blocked", 8'(r.wp & r.ack), 8'(bl_cnt));
      chk("stop count", 8'h01, 8'(sp_cnt));
      if (r.rx) begin
        chk("rx byte", 8'h5a ^ 8'(i), rx_data);
        chk("rx first", 8'h01, 8'(fst));
      end
      $display("test row %0d done", i);
    end
    wp <= 1'b0;
    mst.start();
    mst.put({TWS_TYPE_CODE, strap, 1'b0}, ack);
    mst.put(8'h11, ack);
    mst.start();
    chk("busy rs", 8'h01, 8'(bus_busy));
    mst.put({TWS_TYPE_CODE, strap, 1'b1}, ack);
    chk("rd ack", 8'h01, 8'(ack));
    chk("read mode", 8'h01, 8'(read_mode));
    mst.get(1'b0, d);
    chk("rd byte0", 8'h3c, d);
    mst.get(1'b1, d);
    chk("rd byte1", 8'h3d, d);
    chk("released", 8'h01, 8'(sda));
    chk("idle after nack", 8'h00, 8'(addressed));
    mst.stop();
    chk("stopped", 8'h00, 8'(bus_busy));
    $display("test read done");
    stop_test();
  end
endmodule

bind tws_slave tws_slave_props u_props (
  .clock(clock), .sys_rst(sys_rst), .scl(scl), .sda_oe(sda_oe),
  .write_protect(write_protect), .rx_valid(rx_valid),
  .wr_blocked(wr_blocked), .tx_take(tx_take), .start_seen(start_seen),
  .stop_seen(stop_seen), .bus_busy(bus_busy), .addressed(addressed),
  .read_mode(read_mode));
